//--- pmsc2_apb_slave.v
// Purpose: APB slave decode for the register block
// Assumes: zero wait states
// Notes: one-cycle write and read strobes in the access phase
`timescale 1ns/1ps
`include "pmsc2_consts.vh"
module pmsc2_apb_slave (
   input wire sys_clk,
   input wire rst_b,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PMSC2_ADDR_WIDTH-1:0] paddr,
   output wire pready,
   output wire pslverr,
   output wire wrCtrl,
   output wire wrStatus,
   output wire rdAccess,
   output wire badAddr
);
   wire access;
   wire hitCtrl;
   wire hitStatus;
   assign access = psel & penable;
   assign hitCtrl = (paddr == `PMSC2_CTRL2_OFFSET);
   assign hitStatus = (paddr == `PMSC2_STATUS_OFFSET);
   assign pready = 1'b1;
   assign badAddr = ~(hitCtrl | hitStatus);
   assign pslverr = access & badAddr;
   assign wrCtrl = access & pwrite & hitCtrl;
   assign wrStatus = access & pwrite & hitStatus;
   assign rdAccess = access & ~pwrite;
endmodule // pmsc2_apb_slave

//--- pmsc2_consts.vh
// Purpose: constants for the power management status and control 2 block
// Assumes: APB with 32-bit data, two register words
// Notes: register data sits in the low 8 bits
`ifndef PMSC2_CONSTS_VH
`define PMSC2_CONSTS_VH
`define PMSC2_ADDR_WIDTH 12
`define PMSC2_CTRL2_OFFSET 12'h000
`define PMSC2_STATUS_OFFSET 12'h004
`define PMSC2_BIT_WARN_FLAG 7
`define PMSC2_BIT_WARN_CLEAR 6
`define PMSC2_BIT_DETECT_SEL 5
`define PMSC2_BIT_WARN_SEL 4
`define PMSC2_BIT_PPD_FLAG 3
`define PMSC2_BIT_PPD_CLEAR 2
`define PMSC2_BIT_PD_ALLOW 1
`define PMSC2_BIT_PD_DEPTH 0
`define PMSC2_RESET_VALUE 8'h00
`endif

//--- pmsc2_sync.v
// Purpose: two flip-flop synchroniser for a bus of levels
// Assumes: inputs come from outside sys_clk domain
// Notes: first stage read only by the second stage
`timescale 1ns/1ps
module pmsc2_sync #(
   parameter WIDTH = 4
) (
   input wire sys_clk,
   input wire rst_b,
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] meta_q;
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         meta_q <= {WIDTH{1'b0}};
         syncOut <= {WIDTH{1'b0}};
      end else begin
         meta_q <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule // pmsc2_sync

//--- power_mgmt_status_ctrl2.v
// Purpose: power management status and control 2 register with APB access
// Assumes: analog comparators and reset sources arrive as async levels
// Notes: zero-wait APB, pready and pslverr registered from the setup phase
//
// Functional notes
// - warning flag sets on supply below warning trip, also after any reset (the code clears it on every reset)
// - warning flag is sticky until cleared with no warning present
// - writing 1 to warning clear clears flag only if no warning present
// - bit 5 picks brownout detect trip, 1 high, 0 low
// - bit 4 picks warning trip, 0 low, 1 high
// - partial power-down flag sets on leaving partial power-down mode
// - writing 1 to partial power-down clear clears that flag
// - bit 1 write-once after reset, allows power-down stop modes
// - bit 0 write-once after reset, 0 full, 1 partial power-down
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "pmsc2_consts.vh"
module power_mgmt_status_ctrl2 (
   input wire sys_clk,
   input wire rst_b,
   input wire porReset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PMSC2_ADDR_WIDTH-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire supplyBelowWarnLow,
   input wire supplyBelowWarnHigh,
   input wire stopRequest,
   input wire wakeEvent,
   output reg detectHighSel,
   output reg warnHighSel,
   output reg powerdownAllow,
   output reg powerdownDepthSel,
   output reg fullPowerdownMode,
   output reg partialPowerdownMode
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   wire [3:0] syncPins;
   wire warnLowSync;
   wire warnHighSync;
   wire stopSync;
   wire wakeSync;
   pmsc2_sync #(.WIDTH(4)) pinSync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .asyncIn({wakeEvent, stopRequest, supplyBelowWarnHigh, supplyBelowWarnLow}),
      .syncOut(syncPins)
   );
   assign warnLowSync = syncPins[0];
   assign warnHighSync = syncPins[1];
   assign stopSync = syncPins[2];
   assign wakeSync = syncPins[3];

   // power-on reset is a pin too
   reg porMeta_q;
   reg porSync_q;
   always @(posedge sys_clk) begin
      porMeta_q <= porReset;
      porSync_q <= porMeta_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   wire wrCtrl;
   wire wrStatus;
   wire rdAccess;
   wire badAddr;
   wire decReady;
   wire decErr;
   pmsc2_apb_slave busDecode (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pready(decReady),
      .pslverr(decErr),
      .wrCtrl(wrCtrl),
      .wrStatus(wrStatus),
      .rdAccess(rdAccess),
      .badAddr(badAddr)
   );

   wire setupPhase;
   wire byteWr;
   assign setupPhase = psel & ~penable;
   assign byteWr = wrCtrl & pstrb[0];

   ////////////////////////////////////////////////////////////////////////////
   // register state
   reg warnFlag_q;
   reg ppdFlag_q;
   reg pdAllow_q;
   reg pdDepth_q;
   reg allowWritten_q;
   reg depthWritten_q;
   reg detectSel_q;
   reg warnSel_q;
   reg inPartial_q;

   // active warning follows the selected trip point
   wire warnPresent;
   assign warnPresent = warnSel_q ? warnHighSync : warnLowSync;

   wire warnClear;
   wire ppdClear;
   assign warnClear = byteWr & pwdata[`PMSC2_BIT_WARN_CLEAR];
   assign ppdClear = byteWr & pwdata[`PMSC2_BIT_PPD_CLEAR];

   // warning flag: the set wins over the clear
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         warnFlag_q <= 1'b0;
      end else if (warnPresent) begin
         warnFlag_q <= 1'b1;
      end else if (warnClear) begin
         warnFlag_q <= 1'b0;
      end
   end

   // stop mode tracking and recovery flag
   wire leavePartial;
   assign leavePartial = inPartial_q & wakeSync;
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         inPartial_q <= 1'b0;
      end else if (leavePartial) begin
         inPartial_q <= 1'b0;
      end else if (stopSync & pdAllow_q & pdDepth_q) begin
         inPartial_q <= 1'b1;
      end
   end

   always @(posedge sys_clk) begin
      if (!rst_b) begin
         ppdFlag_q <= 1'b0;
      end else if (leavePartial) begin
         ppdFlag_q <= 1'b1;
      end else if (ppdClear) begin
         ppdFlag_q <= 1'b0;
      end
   end

   // write-once controls
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         pdAllow_q <= 1'b0;
         pdDepth_q <= 1'b0;
         allowWritten_q <= 1'b0;
         depthWritten_q <= 1'b0;
      end else if (byteWr) begin
         if (!allowWritten_q) begin
            pdAllow_q <= pwdata[`PMSC2_BIT_PD_ALLOW];
            allowWritten_q <= 1'b1;
         end
         if (!depthWritten_q) begin
            pdDepth_q <= pwdata[`PMSC2_BIT_PD_DEPTH];
            depthWritten_q <= 1'b1;
         end
      end
   end

   // threshold selects survive all resets but power-on
   always @(posedge sys_clk) begin
      if (porSync_q) begin
         detectSel_q <= 1'b0;
         warnSel_q <= 1'b0;
      end else if (byteWr) begin
         detectSel_q <= pwdata[`PMSC2_BIT_DETECT_SEL];
         warnSel_q <= pwdata[`PMSC2_BIT_WARN_SEL];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data
   function [7:0] ctrlImage;
      input wf;
      input ds;
      input ws;
      input pf;
      input pa;
      input pd;
      begin
         ctrlImage = `PMSC2_RESET_VALUE;
         ctrlImage[`PMSC2_BIT_WARN_FLAG] = wf;
         ctrlImage[`PMSC2_BIT_DETECT_SEL] = ds;
         ctrlImage[`PMSC2_BIT_WARN_SEL] = ws;
         ctrlImage[`PMSC2_BIT_PPD_FLAG] = pf;
         ctrlImage[`PMSC2_BIT_PD_ALLOW] = pa;
         ctrlImage[`PMSC2_BIT_PD_DEPTH] = pd;
      end
   endfunction

   reg [31:0] rdData_d;
   always @* begin
      rdData_d = 32'h00000000;
      if (paddr == `PMSC2_CTRL2_OFFSET) begin
         rdData_d[7:0] = ctrlImage(warnFlag_q, detectSel_q, warnSel_q,
            ppdFlag_q, pdAllow_q, pdDepth_q);
      end else if (paddr == `PMSC2_STATUS_OFFSET) begin
         rdData_d[3:0] = {inPartial_q, warnPresent, depthWritten_q, allowWritten_q};
      end
   end

   // registered answer, loaded in setup so access phase completes at once
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setupPhase & decReady;
         pslverr <= setupPhase & badAddr;
         // unmapped accesses answer with zero data, writes included
         if (setupPhase & (~pwrite | badAddr)) begin
            prdata <= rdData_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs to power controller
   // threshold outputs follow their selects through non-power-on resets
   always @(posedge sys_clk) begin
      detectHighSel <= detectSel_q;
      warnHighSel <= warnSel_q;
   end

   always @(posedge sys_clk) begin
      if (!rst_b) begin
         powerdownAllow <= 1'b0;
         powerdownDepthSel <= 1'b0;
         fullPowerdownMode <= 1'b0;
         partialPowerdownMode <= 1'b0;
      end else begin
         powerdownAllow <= pdAllow_q;
         powerdownDepthSel <= pdDepth_q;
         fullPowerdownMode <= pdAllow_q & ~pdDepth_q;
         partialPowerdownMode <= pdAllow_q & pdDepth_q;
      end
   end
endmodule // power_mgmt_status_ctrl2

//--- power_mgmt_status_ctrl2_assertions.sv
// Purpose: port checks for the power management control 2 register
// Assumes: zero-wait APB, one clock, sync active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
`include "pmsc2_consts.vh"
module power_mgmt_status_ctrl2_checker (
   input wire sys_clk,
   input wire rst_b,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PMSC2_ADDR_WIDTH-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire detectHighSel,
   input wire warnHighSel,
   input wire powerdownAllow,
   input wire powerdownDepthSel,
   input wire fullPowerdownMode,
   input wire partialPowerdownMode
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   sequence s_setup; psel && !penable; endsequence
   sequence s_wr; psel && penable && pwrite && pstrb[0] && paddr == `PMSC2_CTRL2_OFFSET; endsequence
   property p_ready; s_setup |=> pready; endproperty
   property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
   property p_zero; pready && !pwrite |-> prdata[31:8] == 24'h0 && !prdata[6] && !prdata[2];
   endproperty
   property p_det; (s_wr ##0 pwdata[5]) |-> ##[1:2] detectHighSel; endproperty
   property p_warn; (s_wr ##0 !pwdata[4]) |-> ##[1:2] !warnHighSel; endproperty
   property p_allow; powerdownAllow |=> powerdownAllow; endproperty
   property p_depth; powerdownDepthSel |=> powerdownDepthSel; endproperty
   property p_full; fullPowerdownMode |-> powerdownAllow && !powerdownDepthSel; endproperty
   property p_part; partialPowerdownMode |-> powerdownAllow && powerdownDepthSel; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   a_err: assert property (p_err) else $error("error without ready or with data");
   a_zero: assert property (p_zero) else $error("clear or unused bit reads one");
   a_det: assert property (p_det) else $error("detect select not set");
   a_warn: assert property (p_warn) else $error("warning select not cleared");
   a_allow: assert property (p_allow) else $error("allow bit changed");
   a_depth: assert property (p_depth) else $error("depth bit changed");
   a_full: assert property (p_full) else $error("full mode wrong");
   a_part: assert property (p_part) else $error("partial mode wrong");
endmodule // power_mgmt_status_ctrl2_checker
bind power_mgmt_status_ctrl2 power_mgmt_status_ctrl2_checker power_mgmt_status_ctrl2_checker_i (
   .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
   .pslverr, .detectHighSel, .warnHighSel, .powerdownAllow, .powerdownDepthSel,
   .fullPowerdownMode, .partialPowerdownMode);

//--- power_mgmt_status_ctrl2_tb.sv
// Purpose: self-checking bench for the power management control 2 register
// Assumes: zero-wait APB slave, register word at offset zero
// Notes: reads are scored by a monitor against a queue of expected words
`timescale 1ns/1ps
`include "pmsc2_consts.vh"
module power_mgmt_status_ctrl2_tb;
   logic sys_clk, rst_b, porReset, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic supplyBelowWarnLow, supplyBelowWarnHigh, stopRequest, wakeEvent;
   logic detectHighSel, warnHighSel, powerdownAllow, powerdownDepthSel;
   logic fullPowerdownMode, partialPowerdownMode;
   logic [32:0] expQ[$];
   logic [7:0] m, d;
   int mismatches = 0, comparisons = 0, cycles = 0, seed = 28132;
   power_mgmt_status_ctrl2 power_mgmt_status_ctrl2_i (.sys_clk, .rst_b, .porReset, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .supplyBelowWarnLow, .supplyBelowWarnHigh, .stopRequest, .wakeEvent, .detectHighSel,
      .warnHighSel, .powerdownAllow, .powerdownDepthSel, .fullPowerdownMode,
      .partialPowerdownMode);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic bad(input logic ok);
      comparisons++;
      if (!ok) begin
         mismatches++;
         $display("CHECK FAILED at %0t: unexpected value", $time);
      end
   endtask
   // scoreboard: every read answer against the oldest note
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         give_verdict();
      end
      if (pready === 1'b1 && pwrite === 1'b0) bad(expQ.size() != 0 && {pslverr, prdata} === expQ.pop_front());
   end
   // setup then access; request held until ready, left up for back-to-back
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v, input logic e);
      if (!w) expQ.push_back({e, 24'h0, v});
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
      pwdata <= {24'($random(seed)), v};
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
   endtask
   task automatic idle(input int n);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] v); apb(1'b0, `PMSC2_CTRL2_OFFSET, v, 1'b0); endtask
   task automatic wr(input logic [7:0] v); apb(1'b1, `PMSC2_CTRL2_OFFSET, v, 1'b0); endtask
   task automatic reset(input logic por);
      rst_b <= 1'b0; porReset <= por; idle(12); porReset <= 1'b0; idle(4); rst_b <= 1'b1; idle(5);
   endtask
   task automatic warnStep(input logic lo, input logic hi, input logic [7:0] v);
      supplyBelowWarnLow <= lo; supplyBelowWarnHigh <= hi; idle(6); rd(v);
   endtask
   initial begin
      {rst_b, porReset, psel, penable, pwrite, stopRequest, wakeEvent} = '0;
      {supplyBelowWarnLow, supplyBelowWarnHigh, paddr, pwdata, pstrb} = '0;
      pstrb = 4'h1;
      m = 8'h00;
      for (int i = 0; i < 4; i++) begin
         reset(!i[0]);
         m = i[0] ? (m & 8'h30) : 8'h00;
         rd(m);
         d = {8'($random(seed)) & 8'hbb} | 8'(i);
         d[1:0] = 2'(i);
         wr(d); m = d & 8'h33; rd(m);
         wr(~d); m[5:4] = ~d[5:4]; rd(m);
         idle(2);
         bad(fullPowerdownMode === (m[1] & ~m[0]) && partialPowerdownMode === &m[1:0]);
      end
      wr(8'h10); m[5:4] = 2'b01; m[7] = 1'b1;
      warnStep(1'b0, 1'b1, m);
      wr(8'h50); rd(m);
      warnStep(1'b0, 1'b0, m);
      wr(8'h10); rd(m);
      wr(8'h50); m[7] = 1'b0; rd(m);
      wr(8'h00); m[4] = 1'b0;
      warnStep(1'b0, 1'b1, m);
      m[7] = 1'b1;
      warnStep(1'b1, 1'b1, m);
      reset(1'b0); m = m & 8'hb0; rd(m);
      warnStep(1'b0, 1'b0, m);
      wr(8'h43); m = 8'h03; rd(m);
      idle(1); stopRequest <= 1'b1; idle(6); stopRequest <= 1'b0; wakeEvent <= 1'b1; idle(6);
      wakeEvent <= 1'b0; m[3] = 1'b1; rd(m);
      wr(8'h03); rd(m);
      wr(8'h04); m[3] = 1'b0; rd(m);
      pstrb <= 4'he; wr(8'h30); pstrb <= 4'h1; rd(m);
      apb(1'b1, 12'h008, 8'h30, 1'b0); apb(1'b0, 12'h008, 8'h00, 1'b1); rd(m);
      idle(3);
      give_verdict();
   end
endmodule // power_mgmt_status_ctrl2_tb
